// [design/clc_map.svh]
// Constant-light control core: register offsets, field positions, reset values, timing.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef CLC_MAP_SVH
`define CLC_MAP_SVH

`define CLC_OFF_CTRL 12'h000
`define CLC_OFF_SETP 12'h004
`define CLC_OFF_MEAS 12'h008
`define CLC_OFF_OFS 12'h00C
`define CLC_OFF_SYNC 12'h010
`define CLC_OFF_STEP 12'h014
`define CLC_OFF_TIME 12'h018
`define CLC_OFF_STAT 12'h01C
`define CLC_OFF_OUT 12'h020

// CTRL fields
`define CLC_CTRL_EN 0
`define CLC_CTRL_START 1
`define CLC_CTRL_NCH_LO 2
`define CLC_CTRL_NCH_HI 3
`define CLC_CTRL_OFSM_LO 4
`define CLC_CTRL_OFSM_HI 5
`define CLC_CTRL_SUM_LO 6
`define CLC_CTRL_SUM_HI 7
`define CLC_CTRL_REL 8
`define CLC_CTRL_LIMEN 9
`define CLC_CTRL_LIMOFF 10
`define CLC_CTRL_HYS_LO 16
`define CLC_CTRL_HYS_HI 23
`define CLC_CTRL_RST 32'h0000_0004

// STEP fields: min step, lower limit, preset value, rel step code
`define CLC_STEP_RST 32'h0003_8A0A

`define CLC_SETTLE_US 2000
`define CLC_SETTLE_RST 32'h0000_07D0
`define CLC_REPEAT_MS 2
`define CLC_FULL 8'hFF

`endif

// [design/clc_pkg.sv]
// Constant-light control core types.
// Assumes clc_map.svh holds the numeric constants.
package clc_pkg;
  typedef enum logic [1:0] {CLC_OFS_FIXED, CLC_OFS_PROP, CLC_OFS_CONV} clc_ofs_t;
  typedef enum logic [1:0] {CLC_SU_SWITCH, CLC_SU_RELDIM, CLC_SU_PRESET, CLC_SU_ADAPT} clc_su_t;
  typedef enum {CLC_IDLE, CLC_CHECK, CLC_RAMP, CLC_SETTLE, CLC_MAIN, CLC_OFF} clc_state_t;
  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic [7:0] ch1;
    logic [7:0] ch2;
    logic [7:0] ch3;
  } clc_cmd_t;
endpackage

// [design/clc_core.sv]
// Constant-light feedback controller with APB register access.
// Assumes synchronous measured brightness from software and a bus transmitter reading the command output.
`timescale 1ns/10ps
`include "clc_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Proportional dependents saturate at 255
// - Proportional scale in two-percent steps of channel one
// - Converging offset shrinks to zero at sync
// - Converging starts at one; zero forces zero
// - Negative converging offset uses on-off hysteresis
// - Startup skips to main if bright enough
// - Switching startup sends one-bit on, single channel
// - Relative startup steps up then stops
// - Preset startup sends configured absolute value
// - Adaptive startup computes value from brightness range
// - Settle timer before main phase
// - Main regulates with absolute or relative commands
// - Minimum step and minimum command interval
// - Switch-off brightness from setpoint and hystereses
// - Lower limit evaluated only when enabled
// - Switch off at limit and switch-off brightness
// - No-reaction holds output at limit
// - Absolute lower limit configured 1 to 128
// - Relative lower limit tracked from sent steps
// - Multi-channel uses absolute values except the one-bit switch-off
module clc_core
  import clc_pkg::*;
#(
  parameter int CLK_HZ = 50000000,
  parameter int SETTLE_MS = 2000,
  parameter int REPEAT_MS = `CLC_REPEAT_MS
) (
  input wire logic mclk, // 50 MHz clock
  input wire logic resetn, // async reset, low active
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output clc_cmd_t cmd, // command to actuators
  output logic [3:0] dim_step // 4-bit dimming code
);
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int REP_CYC = REPEAT_MS * MS_CYC;

  logic [31:0] ctrl_q, setp_q, meas_q, ofs_q, sync_q, step_q, time_q;
  logic [7:0] out_q;
  logic [31:0] tmr_q;
  logic [31:0] gap_q;
  logic [1:0] dep_on_q;
  logic vld_q;
  clc_state_t st_q;
  clc_cmd_t cmd_q;
  logic [3:0] dim_q;
  logic [7:0] relpos_q;
  logic start_q;

  wire wr = psel && penable && pwrite;
  wire rd_ok = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'b00) && (paddr[5:2] <= 4'h8);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !rd_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `CLC_CTRL_RST;
      setp_q <= 32'h0000_012C;
      meas_q <= 32'h0000_0000;
      ofs_q <= 32'h0000_0000;
      sync_q <= 32'h0000_C8C8;
      step_q <= `CLC_STEP_RST;
      time_q <= `CLC_SETTLE_RST;
    end else if (wr && rd_ok) begin
      case (paddr)
        `CLC_OFF_CTRL: ctrl_q <= pwdata;
        `CLC_OFF_SETP: setp_q <= pwdata;
        `CLC_OFF_MEAS: meas_q <= pwdata;
        `CLC_OFF_OFS: ofs_q <= pwdata;
        `CLC_OFF_SYNC: sync_q <= pwdata;
        `CLC_OFF_STEP: step_q <= pwdata;
        `CLC_OFF_TIME: time_q <= pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      start_q <= 1'b0;
    end else begin
      start_q <= wr && (paddr == `CLC_OFF_CTRL) && pwdata[`CLC_CTRL_START];
    end
  end

  always_comb begin
    case (paddr)
      `CLC_OFF_CTRL: prdata = ctrl_q;
      `CLC_OFF_SETP: prdata = setp_q;
      `CLC_OFF_MEAS: prdata = meas_q;
      `CLC_OFF_OFS: prdata = ofs_q;
      `CLC_OFF_SYNC: prdata = sync_q;
      `CLC_OFF_STEP: prdata = step_q;
      `CLC_OFF_TIME: prdata = time_q;
      `CLC_OFF_STAT: prdata = {24'h000000, relpos_q[3:0], 1'b0, 3'(st_q)};
      `CLC_OFF_OUT: prdata = {8'h00, cmd_q.ch3, cmd_q.ch2, out_q};
      default: prdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration decode
  wire [1:0] nch = ctrl_q[`CLC_CTRL_NCH_HI:`CLC_CTRL_NCH_LO];
  wire multi = nch > 2'd1;
  wire clc_ofs_t ofsm = clc_ofs_t'(ctrl_q[`CLC_CTRL_OFSM_HI:`CLC_CTRL_OFSM_LO]);
  wire clc_su_t sum = clc_su_t'(ctrl_q[`CLC_CTRL_SUM_HI:`CLC_CTRL_SUM_LO]);
  wire rel = ctrl_q[`CLC_CTRL_REL] && !multi;
  wire [7:0] hys_on = ctrl_q[`CLC_CTRL_HYS_HI:`CLC_CTRL_HYS_LO];
  wire [7:0] min_step = step_q[7:0];
  wire [7:0] lim_raw = step_q[15:8];
  wire [7:0] preset_val = step_q[23:16];
  wire [2:0] rel_code = step_q[26:24];
  wire [15:0] sp = setp_q[15:0];
  wire [15:0] meas = meas_q[15:0];
  wire [7:0] sp_hys = setp_q[23:16];
  wire [7:0] add_hys = setp_q[31:24];
  wire [15:0] max_lux = ofs_q[31:16];

  // Clamp lower limit into its permitted span
  wire [7:0] lower_lim = (lim_raw == 8'h00) ? 8'h01 : (lim_raw > 8'h80) ? 8'h80 : lim_raw;
  // Relative mode: limit is reached once tracked steps bring level to minimum step
  wire [7:0] rel_lim = min_step;

  wire [24:0] off_prod = sp * (9'(sp_hys) + 9'(add_hys));
  wire [16:0] off_lux = 17'(sp) + 17'(off_prod / 25'd100);
  wire [24:0] up_prod = sp * sp_hys;
  wire [16:0] up_lux = 17'(sp) + 17'(up_prod / 25'd100);

  // scale deficit against the range's maximum brightness
  wire [15:0] deficit = (meas < sp) ? sp - meas : 16'h0000;
  wire [23:0] adapt_num = deficit * 8'hFF;
  wire [23:0] adapt_q = (max_lux == 16'h0000) ? 24'h0000FF : adapt_num / 24'(max_lux);
  wire [7:0] adapt_val = (adapt_q > 24'h0000FF) ? 8'hFF : (adapt_q == 24'h0) ? 8'h01 : adapt_q[7:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Dependent channels
  logic [7:0] dep [2];
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_dep
      wire [7:0] cfg = ofs_q[gi*8 +: 8];
      wire [7:0] syncp = sync_q[gi*8 +: 8];
      logic signed [10:0] ofs;
      logic [17:0] pr;
      logic signed [10:0] val;
      logic dep_on;
      // Negative offset: on above the offset, off only below offset minus hysteresis
      wire [7:0] thr_on = 8'(-cfg);
      wire [7:0] thr_off = (thr_on > hys_on) ? thr_on - hys_on : 8'h00;
      always_comb begin
        dep_on = (out_q > thr_on) || (dep_on_q[gi] && out_q > thr_off);
        pr = 18'(out_q) * 18'(cfg) * 18'd2 / 18'd100;
        ofs = 11'sd0;
        if (syncp != 8'h00 && out_q < syncp) begin
          // Wide product: offset times distance overflows eleven bits
          ofs = 11'(($signed(20'($signed(cfg))) * $signed(20'({12'h000, syncp - out_q})))
            / $signed(20'({12'h000, syncp - 8'h01})));
        end
        if (ofsm == CLC_OFS_PROP) begin
          val = (pr > 18'd255) ? 11'sd255 : 11'($signed({1'b0, pr[9:0]}));
        end else if (ofsm == CLC_OFS_CONV) begin
          val = $signed({3'b000, out_q}) + ofs;
        end else begin
          val = $signed({3'b000, out_q}) + 11'($signed(cfg));
        end
        if (out_q == 8'h00) begin
          val = 11'sd0;
        end else if (ofsm != CLC_OFS_PROP && cfg[7] && !dep_on) begin
          val = 11'sd0;
        end
      end
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          dep_on_q[gi] <= 1'b0;
        end else begin
          dep_on_q[gi] <= dep_on;
        end
      end
      assign dep[gi] = (val < 0) ? 8'h00 : (val > 11'sd255) ? `CLC_FULL : val[7:0];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Phase sequencer
  wire gap_done = (gap_q == 32'h0);
  wire at_lim = rel ? (relpos_q <= rel_lim) : (out_q <= lower_lim);
  wire need_up = meas < sp;
  wire need_dn = 17'(meas) > up_lux;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= CLC_IDLE;
      out_q <= 8'h00;
      relpos_q <= 8'h00;
      tmr_q <= 32'h0;
      gap_q <= 32'h0;
      cmd_q <= '0;
      dim_q <= 4'h0;
    end else begin
      cmd_q.valid <= 1'b0;
      if (gap_q != 32'h0) gap_q <= gap_q - 32'h1;
      if (tmr_q != 32'h0) tmr_q <= tmr_q - 32'h1;
      if (!ctrl_q[`CLC_CTRL_EN]) begin
        st_q <= CLC_IDLE;
      end else begin
        case (st_q)
          CLC_IDLE: if (start_q) st_q <= CLC_CHECK;
          CLC_CHECK: begin
            if (!need_up) begin
              st_q <= CLC_MAIN;
            end else begin
              cmd_q.valid <= 1'b1;
              case (sum)
                CLC_SU_SWITCH: begin
                  cmd_q.kind <= 2'd0;
                  out_q <= `CLC_FULL;
                  st_q <= CLC_SETTLE;
                end
                CLC_SU_RELDIM: begin
                  cmd_q.kind <= 2'd1;
                  dim_q <= {1'b1, rel_code};
                  gap_q <= 32'(REP_CYC);
                  st_q <= CLC_RAMP;
                end
                CLC_SU_PRESET: begin
                  cmd_q.kind <= 2'd2;
                  out_q <= preset_val;
                  st_q <= CLC_SETTLE;
                end
                default: begin
                  cmd_q.kind <= 2'd2;
                  out_q <= adapt_val;
                  st_q <= CLC_SETTLE;
                end
              endcase
              if (multi && sum < CLC_SU_PRESET) begin
                cmd_q.kind <= 2'd2;
                out_q <= preset_val;
                st_q <= CLC_SETTLE;
              end
              tmr_q <= 32'(time_q[15:0]) * 32'(MS_CYC);
            end
          end
          CLC_RAMP: begin
            if (!need_up) begin
              cmd_q.valid <= 1'b1;
              cmd_q.kind <= 2'd1;
              dim_q <= 4'h0;
              tmr_q <= 32'(time_q[15:0]) * 32'(MS_CYC);
              st_q <= CLC_SETTLE;
            end else if (gap_done) begin
              cmd_q.valid <= 1'b1;
              gap_q <= 32'(REP_CYC);
              relpos_q <= (relpos_q > 8'hF7) ? 8'hFF : relpos_q + 8'h08;
            end
          end
          CLC_SETTLE: if (tmr_q == 32'h0) st_q <= CLC_MAIN;
          CLC_MAIN: if (gap_done) begin
            if (ctrl_q[`CLC_CTRL_LIMEN] && at_lim && !need_up) begin
              if (ctrl_q[`CLC_CTRL_LIMOFF] && 17'(meas) >= off_lux) begin
                cmd_q.valid <= 1'b1;
                cmd_q.kind <= 2'd0;
                out_q <= 8'h00;
                relpos_q <= 8'h00;
                st_q <= CLC_OFF;
              end
            end else if (need_up || need_dn) begin
              cmd_q.valid <= 1'b1;
              gap_q <= time_q[31:16] * 32'(MS_CYC);
              if (rel) begin
                cmd_q.kind <= 2'd1;
                dim_q <= {need_up, rel_code};
                if (need_up) relpos_q <= (relpos_q > 8'hFF - min_step) ? 8'hFF : relpos_q + min_step;
                else relpos_q <= (relpos_q < min_step) ? 8'h00 : relpos_q - min_step;
              end else begin
                cmd_q.kind <= 2'd2;
                if (need_up) out_q <= (out_q > 8'hFF - min_step) ? 8'hFF : out_q + min_step;
                else out_q <= (out_q < min_step) ? 8'h00 : out_q - min_step;
              end
            end
          end
          CLC_OFF: if (start_q) st_q <= CLC_CHECK;
          default: st_q <= CLC_IDLE;
        endcase
      end
      cmd_q.ch1 <= out_q;
      cmd_q.ch2 <= (nch >= 2'd2) ? dep[0] : 8'h00;
      cmd_q.ch3 <= (nch == 2'd3) ? dep[1] : 8'h00;
    end
  end

  // Valid is delayed one cycle so it leaves together with the channel bytes it announces
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      vld_q <= 1'b0;
    end else begin
      vld_q <= cmd_q.valid;
    end
  end

  assign cmd = {vld_q, cmd_q.kind, cmd_q.ch1, cmd_q.ch2, cmd_q.ch3};
  assign dim_step = dim_q;
endmodule

// [verif/clc_sva.sv]
// Checker for the core's bus and command ports.
// Assumes it is bound to every clc_core.
`timescale 1ns/10ps
module clc_sva
  import clc_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic resetn, // reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // write
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input clc_cmd_t cmd // command
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_bad;
    s_acc ##0 (paddr > 12'h020 || paddr[1:0] != 2'h0);
  endsequence
  sequence s_good;
    s_acc ##0 (paddr <= 12'h020 && paddr[1:0] == 2'h0);
  endsequence
  a_ready_high: assert property (pready) else $error("ready low");
  a_err_phase: assert property (pslverr |-> psel && penable) else $error("error outside access");
  a_err_unmap: assert property (s_bad |-> pslverr) else $error("no error on unmapped access");
  a_err_good: assert property (s_good |-> !pslverr) else $error("error on mapped access");
  a_read_zero: assert property (s_bad ##0 !pwrite |-> prdata == 32'h0) else $error("unmapped read not zero");
  a_cmd_pulse: assert property (cmd.valid |=> !cmd.valid) else $error("command stands too long");
  a_off_follow: assert property (cmd.valid && cmd.ch1 == 8'h00 |-> cmd.ch2 == 8'h00 && cmd.ch3 == 8'h00)
    else $error("dependent on while first off");
  a_kind_legal: assert property (cmd.valid |-> cmd.kind != 2'h3) else $error("bad command kind");
endmodule

bind clc_core clc_sva chk_u (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd(cmd));

// [verif/clc_act_model.sv]
// Actuator model: keeps the level of each lighting channel.
// Assumes commands arrive as one-cycle valid pulses.
`timescale 1ns/10ps
module clc_act_model
  import clc_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic resetn, // reset
  input clc_cmd_t cmd, // command
  input wire logic [3:0] dim_step, // dimming code
  output logic [23:0] lvl_q // ch3, ch2, ch1
);
  // No brightness floor: any value down to 1 is taken as sent
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lvl_q <= 24'h0;
    end else if (cmd.valid) begin
      case (cmd.kind)
        2'h0: lvl_q[7:0] <= 8'hFF;
        2'h1: if (dim_step[3] && lvl_q[7:0] < 8'hF0) lvl_q[7:0] <= lvl_q[7:0] + 8'h10;
        default: lvl_q <= {cmd.ch3, cmd.ch2, cmd.ch1};
      endcase
    end
  end
endmodule

// [verif/tb.sv]
// Self-checking bench for the constant-light core.
// Assumes 50 MHz clock; CLK_HZ is cut so a ms is 50 cycles.
`timescale 1ns/10ps
`include "clc_map.svh"
module tb
  import clc_pkg::*;
;
  logic mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  logic [7:0] p, h2, h3;
  logic [3:0] dim_step;
  logic [23:0] lvl;
  clc_cmd_t cmd, c;
  int fail_count = 0, n_compared = 0;
  always #10 mclk = ~mclk;
  clc_core #(.CLK_HZ(50000), .SETTLE_MS(1), .REPEAT_MS(1)) dut_u (.mclk(mclk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd(cmd), .dim_step(dim_step));
  clc_act_model act_u (.mclk(mclk), .resetn(resetn), .cmd(cmd), .dim_step(dim_step), .lvl_q(lvl));
  ////////////////////////////////////////////////////////////
  task summarize;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function logic [31:0] stepw(input logic [7:0] pv);
    return {8'h00, pv, 8'h0A, 8'h02};
  endfunction
  function logic [7:0] prop(input logic [7:0] pv, input logic [7:0] hv);
    int r;
    r = pv * hv * 2 / 100;
    return (r > 255) ? 8'hFF : r[7:0];
  endfunction
  function logic [7:0] conv(input logic [7:0] pv, input int s);
    int r;
    r = (pv == 0) ? 0 : int'(pv) + s * (200 - int'(pv)) / 199;
    return r[7:0];
  endfunction
  // Fresh reset per run so each startup begins from idle
  task run(input logic [31:0] ctrl, input logic [31:0] ofs, input logic [7:0] pv, input logic [31:0] meas);
    @(posedge mclk);
    resetn <= 1'b0;
    @(posedge mclk);
    resetn <= 1'b1;
    apb(1'b1, `CLC_OFF_SETP, 32'h0000_0064);
    apb(1'b1, `CLC_OFF_MEAS, meas);
    apb(1'b1, `CLC_OFF_OFS, ofs);
    apb(1'b1, `CLC_OFF_SYNC, 32'h0000_C8C8);
    apb(1'b1, `CLC_OFF_STEP, stepw(pv));
    apb(1'b1, `CLC_OFF_TIME, 32'h0001_0002);
    apb(1'b1, `CLC_OFF_CTRL, ctrl);
    c = '0;
    for (int i = 0; i < 50 && c.valid !== 1'b1; i++) begin
      @(posedge mclk);
      c = cmd;
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(64));
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    apb(1'b0, `CLC_OFF_CTRL, 32'h0);
    chk(rd, `CLC_CTRL_RST);
    apb(1'b0, `CLC_OFF_STEP, 32'h0);
    chk(rd, `CLC_STEP_RST);
    apb(1'b0, `CLC_OFF_TIME, 32'h0);
    chk(rd, `CLC_SETTLE_RST);
    apb(1'b0, 12'h024, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h006, 32'h0);
    chk(er, 1'b1);
    repeat (4) begin
      v = $urandom;
      apb(1'b1, `CLC_OFF_SETP, v);
      apb(1'b0, `CLC_OFF_SETP, 32'h0);
      chk(rd, v);
    end
    run(32'h0000_0087, 32'h0, 8'h80, 32'h0);
    chk({c.valid, c.kind, c.ch1}, {1'b1, 2'h2, 8'h80});
    @(posedge mclk);
    chk(lvl[7:0], 8'h80);
    repeat (40) @(posedge mclk);
    apb(1'b0, `CLC_OFF_STAT, 32'h0);
    chk(rd[2:0], CLC_SETTLE);
    repeat (100) @(posedge mclk);
    apb(1'b0, `CLC_OFF_STAT, 32'h0);
    chk(rd[2:0], CLC_MAIN);
    run(32'h0000_0007, 32'h0, 8'h80, 32'h0);
    chk({c.valid, c.kind}, {1'b1, 2'h0});
    @(posedge mclk);
    chk(lvl[7:0], 8'hFF);
    run(32'h0000_0047, 32'h0, 8'h80, 32'h0);
    chk({c.valid, c.kind, dim_step}, {1'b1, 2'h1, 4'h8});
    run(32'h0000_0087, 32'h0, 8'h80, 32'h0000_00C8);
    apb(1'b0, `CLC_OFF_STAT, 32'h0);
    chk(rd[2:0], CLC_MAIN);
    for (int k = 0; k < 6; k++) begin
      p = (k == 0) ? 8'd128 : (k == 1) ? 8'd200 : 8'($urandom_range(255, 1));
      h2 = (k < 2) ? 8'd80 : 8'($urandom_range(100, 5));
      h3 = (k < 2) ? 8'd40 : 8'($urandom_range(100, 5));
      run(32'h0000_009F, {16'h00C8, h3, h2}, p, 32'h0);
      chk(c.kind, 2'h2);
      chk(c.ch2, prop(p, h2));
      chk(c.ch3, prop(p, h3));
    end
    for (int j = 0; j < 3; j++) begin
      p = (j == 0) ? 8'd180 : (j == 1) ? 8'd60 : 8'd0;
      run(32'h0014_00AF, 32'h0000_CE32, p, 32'h0);
      chk(c.ch2, conv(p, 50));
      chk(c.ch3, conv(p, -50));
    end
    summarize;
  end
  // About 13 runs of some 30 to 75 cycles each; the limit of 60000 cycles leaves wide margin
  initial begin
    #(20 * 60000);
    fail_count++;
    summarize;
  end
endmodule
